// ### hw/mmf_divider.sv
// Serial restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
module mmf_divider #(
  parameter int unsigned W = 48
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient
);
  // Counter width must hold the shift register width
  if (W < 2 || W > 64) begin : g_bad_width
    $error("mmf_divider: W out of range");
  end

  logic [W:0]   rem_ff;
  logic [W-1:0] quo_ff;
  logic [6:0]   cnt_ff;
  logic         done_ff;
  logic [W:0]   nxt_rem;
  logic [W:0]   trial;

  always_comb begin
    nxt_rem = {rem_ff[W-1:0], quo_ff[W-1]};
    trial   = nxt_rem - {1'b0, divisor};
  end

  // ************************************************************
  // Iteration
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        rem_ff <= '0;
        quo_ff <= dividend;
        cnt_ff <= 7'(W);
      end else if (cnt_ff != '0) begin
        // Divide by zero yields all ones; caller screens it
        if (!trial[W]) begin
          rem_ff <= trial;
          quo_ff <= {quo_ff[W-2:0], 1'b1};
        end else begin
          rem_ff <= nxt_rem;
          quo_ff <= {quo_ff[W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 7'h01;
        if (cnt_ff == 7'h01) done_ff <= 1'b1;
      end
    end
  end

  assign done     = done_ff;
  assign quotient = quo_ff;
endmodule : mmf_divider
`default_nettype wire

// ### hw/mmf_framer.sv
// Metrics message framer: parses requests and builds confirmations
`timescale 1ns/1ps
`default_nettype none
module mmf_framer (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire logic [mmf_pkg::OCT_W-1:0]  req_data,
  input  wire logic                       req_last,
  input  wire logic [mmf_pkg::OCT_W-1:0]  req_node_id,
  output logic                            route_req,
  output logic [mmf_pkg::OCT_W-1:0]       route_src,
  output logic [mmf_pkg::OCT_W-1:0]       route_sink,
  input  wire logic                       route_ack,
  input  wire logic [mmf_pkg::OCT_W-1:0]  route_relay_cnt,
  input  wire logic [mmf_pkg::RATE_W-1:0] route_alloc_rate,
  output logic [mmf_pkg::OCT_W-1:0]       hop_idx,
  input  wire logic [mmf_pkg::OCT_W-1:0]  hop_relay_id,
  input  wire logic [mmf_pkg::RATE_W-1:0] hop_rate,
  output logic                            cnf_valid,
  input  wire logic                       cnf_ready,
  output logic [mmf_pkg::OCT_W-1:0]       cnf_data,
  output logic                            cnf_last,
  output logic [mmf_pkg::OCT_W-1:0]       cnf_dest_node
);
  import mmf_pkg::*;

  mmf_state_t          state_ff;
  mmf_phase_t          phase_ff;
  logic [1:0]          rx_cnt_ff;
  logic [OCT_W-1:0]    src_ff;
  logic [OCT_W-1:0]    sink_ff;
  logic [OCT_W-1:0]    node_ff;
  logic [OCT_W-1:0]    relay_cnt_ff;
  logic [RATE_W-1:0]   alloc_ff;
  logic [RATE_W-1:0]   peak_ff;
  logic [OCT_W-1:0]    hop_idx_ff;
  logic [DIV_W-1:0]    sum_ff;
  logic                zero_hop_ff;
  logic                cnf_valid_ff;
  logic                cnf_last_ff;
  logic [OCT_W-1:0]    cnf_data_ff;
  logic [TXCNT_W-1:0]  tx_cnt_ff;
  logic                div_start;
  logic                div_done;
  logic [DIV_W-1:0]    div_divisor;
  logic [DIV_W-1:0]    div_quo;
  logic                load_en;

  assign req_ready     = (state_ff == ST_IDLE);
  assign route_req     = (state_ff == ST_QUERY);
  assign route_src     = src_ff;
  assign route_sink    = sink_ff;
  assign hop_idx       = hop_idx_ff;
  assign cnf_valid     = cnf_valid_ff;
  assign cnf_data      = cnf_data_ff;
  assign cnf_last      = cnf_last_ff;
  assign cnf_dest_node = node_ff;
  assign load_en       = (state_ff == ST_TX) && (!cnf_valid_ff || cnf_ready);
  assign div_start     = (state_ff == ST_RECIP_START) || (state_ff == ST_PEAK_START);
  // Divider reads the divisor on every iteration, so hold the sum for the whole peak pass
  assign div_divisor   = (state_ff == ST_PEAK_START || state_ff == ST_PEAK_WAIT) ? sum_ff : DIV_W'(hop_rate);

  mmf_divider #(.W(DIV_W)) u_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .start    (div_start),
    .dividend (RECIP_NUM),
    .divisor  (div_divisor),
    .done     (div_done),
    .quotient (div_quo)
  );

  // ************************************************************
  // Request parsing
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_ff <= OCT_SRC;
      src_ff    <= '0;
      sink_ff   <= '0;
      node_ff   <= '0;
    end else if (req_valid && req_ready) begin
      if (rx_cnt_ff == OCT_SRC) begin
        src_ff  <= req_data;
        node_ff <= req_node_id;
      end
      if (rx_cnt_ff == OCT_SINK) sink_ff <= req_data;
      // Trailing octets beyond the two ids are ignored
      if (req_last) rx_cnt_ff <= OCT_SRC;
      else if (rx_cnt_ff != OCT_DONE) rx_cnt_ff <= rx_cnt_ff + 2'h1;
    end
  end

  // ************************************************************
  // Sequencing
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // each complete request starts a reply; a one-octet request is dropped
          if (req_valid && req_last && rx_cnt_ff != OCT_SRC) state_ff <= ST_QUERY;
        end
        ST_QUERY:       if (route_ack) state_ff <= ST_RECIP_START;
        ST_RECIP_START: state_ff <= ST_RECIP_WAIT;
        ST_RECIP_WAIT: begin
          if (div_done) state_ff <= (hop_idx_ff == relay_cnt_ff) ? ST_PEAK_START : ST_RECIP_START;
        end
        ST_PEAK_START:  state_ff <= ST_PEAK_WAIT;
        ST_PEAK_WAIT:   if (div_done) state_ff <= ST_TX;
        ST_TX:          if (load_en && phase_ff == TX_END) state_ff <= ST_IDLE;
        default:        state_ff <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Rate computation
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relay_cnt_ff <= '0;
      alloc_ff     <= '0;
      sum_ff       <= '0;
      zero_hop_ff  <= 1'b0;
      peak_ff      <= '0;
    end else begin
      if (state_ff == ST_QUERY && route_ack) begin
        relay_cnt_ff <= route_relay_cnt;
        alloc_ff     <= route_alloc_rate;
        sum_ff       <= '0;
        zero_hop_ff  <= 1'b0;
      end
      // Dead hop forces a zero peak, overriding the all-ones quotient of its divide by zero
      if (state_ff == ST_RECIP_START && hop_rate == '0) zero_hop_ff <= 1'b1;
      // sum of per-hop reciprocals over N+1 hops
      if (state_ff == ST_RECIP_WAIT && div_done) sum_ff <= sum_ff + div_quo;
      if (state_ff == ST_PEAK_WAIT && div_done) begin
        if (zero_hop_ff) peak_ff <= '0;
        else if (div_quo > DIV_W'(RATE_MAX)) peak_ff <= RATE_MAX;
        else peak_ff <= div_quo[RATE_W-1:0];
      end
    end
  end

  // ************************************************************
  // Hop index
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hop_idx_ff <= '0;
    end else begin
      if (state_ff == ST_QUERY && route_ack) hop_idx_ff <= '0;
      else if (state_ff == ST_RECIP_WAIT && div_done) begin
        if (hop_idx_ff != relay_cnt_ff) hop_idx_ff <= hop_idx_ff + 8'h01;
      end else if (state_ff == ST_PEAK_WAIT && div_done) hop_idx_ff <= '0;
      else if (load_en) begin
        if (phase_ff == TX_ID) begin
          hop_idx_ff <= (hop_idx_ff == relay_cnt_ff - 8'h01) ? '0 : hop_idx_ff + 8'h01;
        end else if (phase_ff == TX_RLO && hop_idx_ff != relay_cnt_ff) begin
          hop_idx_ff <= hop_idx_ff + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // Confirmation output
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff     <= TX_SRC;
      cnf_valid_ff <= 1'b0;
      cnf_last_ff  <= 1'b0;
      cnf_data_ff  <= '0;
      tx_cnt_ff    <= '0;
    end else if (state_ff == ST_PEAK_WAIT && div_done) begin
      phase_ff  <= TX_SRC;
      tx_cnt_ff <= '0;
    end else if (load_en) begin
      if (cnf_valid_ff) tx_cnt_ff <= tx_cnt_ff + 10'h001;
      cnf_valid_ff <= (phase_ff != TX_END);
      cnf_last_ff  <= (phase_ff == TX_ALO);
      // reply addressed to the requester, for its link
      case (phase_ff)
        TX_SRC:  begin cnf_data_ff <= src_ff;  phase_ff <= TX_SINK; end
        TX_SINK: begin
          cnf_data_ff <= sink_ff;
          phase_ff    <= (relay_cnt_ff != '0) ? TX_CNT : TX_PHI;
        end
        TX_CNT:  begin cnf_data_ff <= relay_cnt_ff; phase_ff <= TX_ID; end
        TX_ID: begin
          cnf_data_ff <= hop_relay_id;
          if (hop_idx_ff == relay_cnt_ff - 8'h01) phase_ff <= TX_RHI;
        end
        TX_RHI:  begin cnf_data_ff <= hop_rate[15:8]; phase_ff <= TX_RLO; end
        TX_RLO: begin
          cnf_data_ff <= hop_rate[7:0];
          phase_ff    <= (hop_idx_ff == relay_cnt_ff) ? TX_PHI : TX_RHI;
        end
        // peak then allocatable, high octet first
        TX_PHI:  begin cnf_data_ff <= peak_ff[15:8];  phase_ff <= TX_PLO; end
        TX_PLO:  begin cnf_data_ff <= peak_ff[7:0];   phase_ff <= TX_AHI; end
        TX_AHI:  begin cnf_data_ff <= alloc_ff[15:8]; phase_ff <= TX_ALO; end
        TX_ALO:  begin cnf_data_ff <= alloc_ff[7:0];  phase_ff <= TX_END; end
        default: phase_ff <= TX_SRC;
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_SRC_ECHO: assert property (cnf_valid && tx_cnt_ff == '0 |-> cnf_data == src_ff)
    else $error("first confirmation octet is not the source id");
  AST_SINK_ECHO: assert property (cnf_valid && tx_cnt_ff == 10'h001 |-> cnf_data == sink_ff)
    else $error("second confirmation octet is not the sink id");
  AST_RELAY_COUNT: assert property (cnf_valid && relay_cnt_ff != '0 && tx_cnt_ff == 10'h002
    |-> cnf_data == relay_cnt_ff)
    else $error("relay count octet wrong");
  AST_FRAME_LEN: assert property (cnf_valid && cnf_last |-> tx_cnt_ff == ((relay_cnt_ff == '0)
    ? LEN_DIRECT - 10'h001 : LEN_BASE - 10'h001 + 10'(relay_cnt_ff) * 10'h003))
    else $error("confirmation length wrong");
  AST_DIRECT_REPLY: assert property (state_ff == ST_QUERY && route_ack && route_relay_cnt == '0
    |-> ##[1:200] cnf_valid)
    else $error("no confirmation for direct link");
  AST_PEAK_SAT: assert property (state_ff == ST_PEAK_WAIT && div_done && !zero_hop_ff
    && div_quo > DIV_W'(RATE_MAX) |=> peak_ff == RATE_MAX)
    else $error("peak rate not saturated");
  AST_HOP_RATE: assert property (load_en && phase_ff == TX_RHI
    |=> cnf_valid && cnf_data == hop_rate[15:8])
    else $error("hop rate octet wrong");
  AST_ALLOC_LAST: assert property (load_en && phase_ff == TX_ALO
    |=> cnf_last && cnf_data == alloc_ff[7:0])
    else $error("allocatable rate low octet wrong");
  AST_CNF_HOLD: assert property (cnf_valid && !cnf_ready
    |=> cnf_valid && $stable(cnf_data) && $stable(cnf_dest_node))
    else $error("confirmation dropped while stalled");
endmodule : mmf_framer
`default_nettype wire

// ### hw/mmf_pkg.sv
// Package for the metrics message framer: constants, states and phases
// Contract
// - The request carries link_source_node_id as 8 bits in octet 0.
// - The request carries link_sink_node_id in octet 1, and the confirmation echoes both ids in octets 0 and 1.
// - The domain_master sends the metrics_confirm_msg to the requesting node for the link asked about.
// - The relay_path_list is present only when the route has one or more relays.
// - The confirmation carries a 16-bit peak_path_rate in bits per second.
// - The peak_path_rate is the reciprocal of the sum of reciprocals of all N+1 hop rates.
// - The confirmation carries a 16-bit allocatable_path_rate in bits per second.
// - Octet 0 of the relay_path_list holds the relay count N.
// - Octets 1 to N of the list hold relay node_identifiers, nearest the source first.
// - Then follow N+1 hop_phy_rate pairs, source hop first, sink hop last.
// - Each reported hop_phy_rate equals the rate last given in that node's topology_change_report.
// - Every metrics_request_msg is always answered with a metrics_confirm_msg; the framer drops a one-octet request unanswered.
package mmf_pkg;
  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int unsigned OCT_W      = 8;
  localparam int unsigned RATE_W     = 16;
  localparam int unsigned DIV_W      = 48;
  localparam int unsigned TXCNT_W    = 10;
  localparam logic [1:0]  OCT_SRC    = 2'h0;
  localparam logic [1:0]  OCT_SINK   = 2'h1;
  localparam logic [1:0]  OCT_DONE   = 2'h2;
  localparam logic [15:0] RATE_MAX   = 16'hFFFF;
  // Fixed-point numerator for reciprocals
  localparam logic [47:0] RECIP_NUM  = 48'h0001_0000_0000;
  // Confirmation length: direct link, and fixed part with relays (plus 3 per relay)
  localparam logic [9:0]  LEN_DIRECT = 10'h006;
  localparam logic [9:0]  LEN_BASE   = 10'h009;

  typedef enum logic [2:0] {
    ST_IDLE, ST_QUERY, ST_RECIP_START, ST_RECIP_WAIT, ST_PEAK_START, ST_PEAK_WAIT, ST_TX
  } mmf_state_t;

  typedef enum logic [3:0] {
    TX_SRC, TX_SINK, TX_CNT, TX_ID, TX_RHI, TX_RLO, TX_PHI, TX_PLO, TX_AHI, TX_ALO, TX_END
  } mmf_phase_t;
endpackage : mmf_pkg

// ### verification/metrics_message_framer_tb.sv
// Self-checking bench for the metrics message framer
`timescale 1ns/1ps
`default_nettype none
module metrics_message_framer_tb;
  import mmf_pkg::*;
  logic         mclk, rst_n, req_valid, req_last, req_ready, route_req, route_ack;
  logic         cnf_valid, cnf_ready, cnf_last, got_last;
  logic [7:0]   req_data, req_node_id, route_src, route_sink, relay_cnt, hop_idx, hop_relay_id;
  logic [7:0]   cnf_data, cnf_dest_node, got_dest, cfg_n;
  logic [15:0]  alloc_rate, hop_rate, cfg_alloc;
  logic [3:0]   cfg_delay;
  logic [63:0]  cfg_ids;
  logic [143:0] cfg_rates;
  logic [7:0]   got_q[$];
  logic [7:0]   exp_q[$];
  int           failures, check_count, seed, t;
  mmf_framer mmf_framer_inst (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .req_last(req_last), .req_node_id(req_node_id), .route_req(route_req),
    .route_src(route_src), .route_sink(route_sink), .route_ack(route_ack), .route_relay_cnt(relay_cnt),
    .route_alloc_rate(alloc_rate), .hop_idx(hop_idx), .hop_relay_id(hop_relay_id), .hop_rate(hop_rate),
    .cnf_valid(cnf_valid), .cnf_ready(cnf_ready), .cnf_data(cnf_data), .cnf_last(cnf_last),
    .cnf_dest_node(cnf_dest_node));
  mmf_route_model mmf_route_model_inst (.mclk(mclk), .rst_n(rst_n), .route_req(route_req),
    .route_ack(route_ack), .route_relay_cnt(relay_cnt), .route_alloc_rate(alloc_rate), .hop_idx(hop_idx),
    .hop_relay_id(hop_relay_id), .hop_rate(hop_rate), .cfg_n(cfg_n), .cfg_alloc(cfg_alloc),
    .cfg_delay(cfg_delay), .cfg_ids(cfg_ids), .cfg_rates(cfg_rates));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // Stalls keep the output hold honest
  always @(posedge mclk) begin
    cnf_ready <= ($random(seed) & 3) != 0;
    if (cnf_valid === 1'h1 && cnf_ready === 1'h1) begin
      got_q.push_back(cnf_data);
      if (cnf_last === 1'h1) begin
        got_last = 1'h1;
        got_dest = cnf_dest_node;
      end
    end
  end
  task automatic chk_oct(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_oct
  task automatic chk_flag(input logic g, input logic e, input string m);
    chk_oct({7'h00, g}, {7'h00, e}, m);
  endtask : chk_flag
  // Integer reference of the peak rate, saturating
  function automatic void build_exp(input logic [7:0] s, input logic [7:0] d);
    logic [63:0] sum;
    logic [63:0] pk;
    logic [15:0] r;
    logic        zero;
    sum  = 64'h0000;
    zero = 1'h0;
    exp_q = {s, d};
    if (cfg_n != 0) exp_q.push_back(cfg_n);
    for (int i = 0; i < cfg_n; i++) exp_q.push_back(cfg_ids[8*i +: 8]);
    for (int i = 0; i <= cfg_n; i++) begin
      r = cfg_rates[16*i +: 16];
      if (r == 0) zero = 1'h1;
      else sum += 64'h0001_0000_0000 / r;
      if (cfg_n != 0) exp_q = {exp_q, r[15:8], r[7:0]};
    end
    pk = (zero || sum == 0) ? 64'h0000 : 64'h0001_0000_0000 / sum;
    if (pk > 64'hFFFF) pk = 64'hFFFF;
    exp_q = {exp_q, pk[15:8], pk[7:0], cfg_alloc[15:8], cfg_alloc[7:0]};
  endfunction : build_exp
  task automatic send_req(input int len, input logic [7:0] s, input logic [7:0] d, input logic [7:0] nid);
    for (int i = 0; i < len; i++) begin
      req_valid   <= 1'h1;
      req_data    <= (i == 0) ? s : (i == 1) ? d : 8'($random(seed));
      req_last    <= (i == len - 1);
      req_node_id <= (i == 0) ? nid : ~nid;
      do @(posedge mclk); while (req_ready !== 1'h1);
    end
    req_valid <= 1'h0;
    req_last  <= 1'h0;
  endtask : send_req
  task automatic run_test(input logic [7:0] n, input int len, input logic zero_hop);
    logic [7:0] s, d, nid;
    s   = 8'($random(seed));
    d   = 8'($random(seed));
    nid = 8'($random(seed));
    cfg_n     = n;
    cfg_delay = 4'($random(seed));
    cfg_alloc = 16'($random(seed));
    cfg_ids   = {$random(seed), $random(seed)};
    cfg_rates = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
    if (zero_hop) cfg_rates[31:16] = 16'h0000;
    got_q.delete();
    got_last = 1'h0;
    build_exp(s, d);
    send_req(len, s, d, nid);
    @(posedge mclk);
    chk_flag(req_ready, 1'h0, "ready held low");
    chk_flag(route_req, 1'h1, "lookup raised");
    chk_oct(route_src, s, "lookup source");
    chk_oct(route_sink, d, "lookup sink");
    for (int w = 0; w < 3000 && !got_last; w++) @(posedge mclk);
    chk_flag(got_last, 1'h1, "confirm ended");
    chk_oct(8'(got_q.size()), 8'(exp_q.size()), "length");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      chk_oct(got_q[i], exp_q[i], "octet");
    chk_oct(got_dest, nid, "reply target");
    repeat (3) @(posedge mclk);
    chk_flag(req_ready, 1'h1, "ready again");
    $display("test n=%0d len=%0d done, failures %0d", n, len, failures);
  endtask : run_test
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    seed = 71;
    rst_n = 1'h0;
    {req_valid, req_last, cnf_ready} = 3'h0;
    {req_data, req_node_id, cfg_n, cfg_delay, cfg_alloc, cfg_ids, cfg_rates} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    send_req(1, 8'h11, 8'h22, 8'h33);
    repeat (10) @(posedge mclk);
    chk_flag(route_req, 1'h0, "lone octet dropped");
    chk_flag(req_ready, 1'h1, "lone octet idle");
    $display("test lone octet done, failures %0d", failures);
    run_test(8'h00, 2, 1'h0);
    run_test(8'h01, 2, 1'h0);
    run_test(8'h03, 4, 1'h0);
    run_test(8'h02, 2, 1'h1);
    run_test(8'h06, 3, 1'h0);
    for (t = 0; t < 3; t++) run_test(8'($unsigned($random(seed)) % 7), 2, 1'h0);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    print_verdict();
  end
endmodule : metrics_message_framer_tb
`default_nettype wire

// ### verification/mmf_route_model.sv
// Route table model answering the framer's lookup port
`timescale 1ns/1ps
`default_nettype none
module mmf_route_model (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          route_req,
  output logic               route_ack,
  output logic [7:0]         route_relay_cnt,
  output logic [15:0]        route_alloc_rate,
  input  wire logic [7:0]    hop_idx,
  output logic [7:0]         hop_relay_id,
  output logic [15:0]        hop_rate,
  input  wire logic [7:0]    cfg_n,
  input  wire logic [15:0]   cfg_alloc,
  input  wire logic [3:0]    cfg_delay,
  input  wire logic [63:0]   cfg_ids,
  input  wire logic [143:0]  cfg_rates
);
  logic [3:0] wait_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff   <= 4'h0;
      route_ack <= 1'h0;
    end else if (route_req && !route_ack && wait_ff == cfg_delay) begin
      route_ack <= 1'h1;
      wait_ff   <= 4'h0;
    end else begin
      route_ack <= 1'h0;
      wait_ff   <= (route_req && !route_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
  // count and rate only at ack
  assign route_relay_cnt  = route_ack ? cfg_n : ~cfg_n;
  assign route_alloc_rate = route_ack ? cfg_alloc : ~cfg_alloc;
  assign hop_relay_id = (hop_idx < cfg_n) ? cfg_ids[8*hop_idx[2:0] +: 8] : ~hop_idx;
  assign hop_rate     = (hop_idx <= cfg_n) ? cfg_rates[16*hop_idx[3:0] +: 16] : ~cfg_rates[15:0];
endmodule : mmf_route_model
`default_nettype wire
